// ==== rtl/abn_quadrature_encoder_counter.sv ====
// Quadrature encoder counter with scaling, null handling and an AXI4-Lite slave.
`timescale 1ns/10ps
// Notes on behaviour
// - Counting works without the null input.
// - Null event clears or snapshots the position.
// - Continuous flag acts on every null event.
// - Single-shot flag acts once, then self-clears.
// - Null accepted only at selected A/B levels.
// - Clear needs clear-enable and a null flag.
// - Each A/B change adds or subtracts scale.
// - Scale is signed 16.16, fraction accumulates.
// - Decimal mode fraction ranges 0 to 9999.
// - Position is readable at any time.
// - Status records a null-triggered clear.
// - Latch register captures position on null.
// - Filtering limits each A/B line to one change per four clocks.
// - Inputs pass a three-cycle spike filter.
module abn_quadrature_encoder_counter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic encA,
	input wire logic encB,
	input wire logic encN,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);

	// Filtered encoder levels, ordered A, B, N.
	logic [2:0] pinRaw;
	logic [2:0] pinFilt;
	// Levels of A and B from the previous cycle.
	logic prevA;
	logic prevB;
	// Previous qualified null level, for edge detection.
	logic prevNQual;

	// Software-visible state.
	logic [31:0] encoderModeConfig;
	logic [31:0] globalConfig;
	logic [31:0] scale;
	logic [31:0] position;
	logic [15:0] fraction;
	logic [31:0] latchValue;
	localparam int ST_W_MAX = abn_encoder_pkg::ST_W - 1;
	logic [ST_W_MAX:0] status;
	logic [ST_W_MAX:0] irqEnable;

	// Held write address, write data and strobes of the AXI slave.
	logic [7:0] wrAddr;
	logic awHeld;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wHeld;

	// Derived step and event signals.
	logic stepUp;
	logic stepDown;
	logic nActive;
	logic abMatch;
	logic nQual;
	logic nEvent;
	logic armed;
	logic doClear;
	logic wrFire;
	logic [31:0] wrMerged;
	logic [31:0] next_position;
	logic [15:0] next_fraction;
	logic [31:0] readWord;
	logic readOk;
	// Bits that set and that clear the sticky status in this cycle.
	logic [ST_W_MAX:0] statusSet;
	logic [ST_W_MAX:0] statusClr;

	// Each pin gets its own synchroniser and spike filter.
	assign pinRaw = {encN, encB, encA};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : gen_filter
			abn_input_filter u_filter (
				.core_clk(core_clk),
				.rst(rst),
				.pinIn(pinRaw[gi]),
				.filtered(pinFilt[gi])
			);
		end
	endgenerate

	// Remember the last filtered A, B and qualified N levels.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			prevA <= 1'b0;
			prevB <= 1'b0;
			prevNQual <= 1'b0;
		end
		else
		begin
			prevA <= pinFilt[0];
			prevB <= pinFilt[1];
			prevNQual <= nQual;
		end
	end

	// Gray sequence 00-10-11-01 counts up, the reverse down; a double change is dropped.
	always_comb
	begin
		stepUp = 1'b0;
		stepDown = 1'b0;
		case ({prevA, prevB, pinFilt[0], pinFilt[1]})
			4'b0010, 4'b1011, 4'b1101, 4'b0100: stepUp = 1'b1;
			4'b0001, 4'b0111, 4'b1110, 4'b1000: stepDown = 1'b1;
			default:
			begin
				// No change, or an invalid simultaneous change of A and B.
				stepUp = 1'b0;
				stepDown = 1'b0;
			end
		endcase
	end

	// Null qualification: active level of N while A and B match their selected levels.
	assign nActive = (pinFilt[2] == encoderModeConfig[abn_encoder_pkg::MODE_N_POL]);
	assign abMatch = (pinFilt[0] == encoderModeConfig[abn_encoder_pkg::MODE_POL_A]) &&
		(pinFilt[1] == encoderModeConfig[abn_encoder_pkg::MODE_POL_B]);
	// With the null input unused the event path stays quiet.
	assign nQual = nActive && abMatch && globalConfig[abn_encoder_pkg::GLOB_N_USED];
	assign nEvent = nQual && !prevNQual;
	// Either null flag arms the event handling.
	assign armed = encoderModeConfig[abn_encoder_pkg::MODE_CLR_CONT] ||
		encoderModeConfig[abn_encoder_pkg::MODE_CLR_ONCE];
	// Clearing additionally needs the clear-enable flag.
	assign doClear = nEvent && armed && encoderModeConfig[abn_encoder_pkg::MODE_CLR_ENC];

	// Scaled accumulation of one quadrature step in binary or decimal mode.
	always_comb
	begin
		logic [16:0] fracSum;
		logic [31:0] intPart;
		logic carry;
		fracSum = '0;
		intPart = {{16{scale[31]}}, scale[31:16]};
		carry = 1'b0;
		next_position = position;
		next_fraction = fraction;
		if (stepUp)
		begin
			fracSum = {1'b0, fraction} + {1'b0, scale[15:0]};
			if (encoderModeConfig[abn_encoder_pkg::MODE_DECIMAL])
			begin
				// Decimal fraction wraps at ten thousand.
				carry = (fracSum >= abn_encoder_pkg::DEC_WRAP);
				if (carry)
				begin
					fracSum = fracSum - abn_encoder_pkg::DEC_WRAP;
				end
			end
			else
			begin
				// Binary fraction carries out of bit 15.
				carry = fracSum[16];
			end
			next_fraction = fracSum[15:0];
			next_position = position + intPart + {31'h00000000, carry};
		end
		else if (stepDown)
		begin
			fracSum = {1'b0, fraction} - {1'b0, scale[15:0]};
			carry = fracSum[16];
			if (encoderModeConfig[abn_encoder_pkg::MODE_DECIMAL] && carry)
			begin
				// Decimal borrow adds ten thousand back to the fraction.
				fracSum = fracSum + abn_encoder_pkg::DEC_WRAP;
			end
			next_fraction = fracSum[15:0];
			next_position = position - intPart - {31'h00000000, carry};
		end
		else
		begin
			next_position = position;
			next_fraction = fraction;
		end
	end

	// Write data merged with the held register under the byte strobes.
	always_comb
	begin
		logic [31:0] oldWord;
		oldWord = 32'h00000000;
		case (wrAddr)
			abn_encoder_pkg::OFS_MODE: oldWord = encoderModeConfig;
			abn_encoder_pkg::OFS_POSITION: oldWord = position;
			abn_encoder_pkg::OFS_SCALE: oldWord = scale;
			abn_encoder_pkg::OFS_IRQ_EN: oldWord = {{(32 - abn_encoder_pkg::ST_W){1'b0}}, irqEnable};
			abn_encoder_pkg::OFS_GLOBAL: oldWord = globalConfig;
			default: oldWord = 32'h00000000;
		endcase
		for (int i = 0; i < 4; i++)
		begin
			wrMerged[i*8 +: 8] = wrStrb[i] ? wrData[i*8 +: 8] : oldWord[i*8 +: 8];
		end
	end

	// A write is carried out once address and data are both held.
	assign wrFire = awHeld && wHeld && !s_axi_bvalid;

	// Position and fraction: software write first, then null clear, then counting.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			position <= 32'h00000000;
			fraction <= 16'h0000;
		end
		else if (wrFire && (wrAddr == abn_encoder_pkg::OFS_POSITION))
		begin
			// Software sets the integer position; the fraction restarts.
			position <= wrMerged;
			fraction <= 16'h0000;
		end
		else if (doClear)
		begin
			// Null event clears the counter.
			position <= 32'h00000000;
			fraction <= 16'h0000;
		end
		else
		begin
			// Count on each A/B change; the filters cap the rate.
			position <= next_position;
			fraction <= next_fraction;
		end
	end

	// Snapshot of the position on every armed null event, before any clear.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			latchValue <= 32'h00000000;
		end
		else if (nEvent && armed)
		begin
			latchValue <= position;
		end
	end

	// Mode register; the single-shot flag drops by itself after its event.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			encoderModeConfig <= abn_encoder_pkg::MODE_RESET;
		end
		else
		begin
			if (wrFire && (wrAddr == abn_encoder_pkg::OFS_MODE))
			begin
				encoderModeConfig <= wrMerged & abn_encoder_pkg::MODE_MASK;
			end
			if (nEvent && armed)
			begin
				// Hardware clear of the once flag wins over a write in the same cycle.
				encoderModeConfig[abn_encoder_pkg::MODE_CLR_ONCE] <= 1'b0;
			end
		end
	end

	// Scale constant, global configuration and interrupt enables.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			scale <= abn_encoder_pkg::SCALE_RESET;
			globalConfig <= abn_encoder_pkg::GLOB_RESET;
			irqEnable <= '0;
		end
		else if (wrFire)
		begin
			case (wrAddr)
				abn_encoder_pkg::OFS_SCALE: scale <= wrMerged;
				abn_encoder_pkg::OFS_GLOBAL: globalConfig <= {31'h00000000, wrMerged[0]};
				abn_encoder_pkg::OFS_IRQ_EN: irqEnable <= wrMerged[ST_W_MAX:0];
				default:
				begin
					// Other offsets leave these registers alone.
					scale <= scale;
				end
			endcase
		end
	end

	// Events of this cycle, and the bits that software asks to clear.
	assign statusSet = {nEvent && armed, doClear};
	assign statusClr = (wrFire && (wrAddr == abn_encoder_pkg::OFS_STATUS_CLR)) ?
		wrMerged[ST_W_MAX:0] : '0;

	// Sticky status; a new event wins over a clear in the same cycle.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			status <= '0;
		end
		else
		begin
			status <= (status & ~statusClr) | statusSet;
		end
	end

	// Level interrupt while an enabled status bit is set.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(status & irqEnable);
		end
	end

	// Write address and data channels, taken in either order.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 32'h00000000;
			wrStrb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				// Address held; only aligned words inside the map decode.
				wrAddr <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hFF;
				awHeld <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wrData <= s_axi_wdata;
				wrStrb <= s_axi_wstrb;
				wHeld <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wrFire)
			begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response one cycle after both halves are held.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= abn_encoder_pkg::RESP_OKAY;
		end
		else if (wrFire)
		begin
			s_axi_bvalid <= 1'b1;
			case (wrAddr)
				abn_encoder_pkg::OFS_MODE, abn_encoder_pkg::OFS_POSITION, abn_encoder_pkg::OFS_SCALE,
				abn_encoder_pkg::OFS_STATUS_CLR, abn_encoder_pkg::OFS_IRQ_EN,
				abn_encoder_pkg::OFS_GLOBAL: s_axi_bresp <= abn_encoder_pkg::RESP_OKAY;
				default: s_axi_bresp <= abn_encoder_pkg::RESP_SLVERR;
			endcase
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read decode; position and latch are readable at any time.
	always_comb
	begin
		readWord = 32'h00000000;
		readOk = 1'b1;
		if (s_axi_araddr[31:8] != 24'h000000)
		begin
			readOk = 1'b0;
		end
		else
		begin
			case (s_axi_araddr[7:0])
				abn_encoder_pkg::OFS_MODE: readWord = encoderModeConfig;
				abn_encoder_pkg::OFS_POSITION: readWord = position;
				abn_encoder_pkg::OFS_SCALE: readWord = scale;
				abn_encoder_pkg::OFS_LATCH: readWord = latchValue;
				abn_encoder_pkg::OFS_STATUS: readWord = {30'h00000000, status};
				abn_encoder_pkg::OFS_STATUS_CLR: readWord = 32'h00000000;
				abn_encoder_pkg::OFS_IRQ_EN: readWord = {30'h00000000, irqEnable};
				abn_encoder_pkg::OFS_GLOBAL: readWord = globalConfig;
				default: readOk = 1'b0;
			endcase
		end
	end

	// Read channel: address taken, data returned on the next cycle.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= abn_encoder_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= readWord;
			s_axi_rresp <= readOk ? abn_encoder_pkg::RESP_OKAY : abn_encoder_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : abn_quadrature_encoder_counter

// ==== rtl/abn_encoder_pkg.sv ====
// Constants shared by the quadrature encoder counter and its input filter.
package abn_encoder_pkg;

	// Clock period of core_clk in nanoseconds.
	localparam int CLK_PERIOD_NS = 10;
	// Spike filtering time of the A, B and N inputs in nanoseconds.
	localparam int FILTER_TIME_NS = 30;
	// Filter time as a whole number of clock cycles, rounded up.
	localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Width of the filter's stability counter.
	localparam int FILTER_CNT_W = 4;

	// Byte offsets of the registers on the AXI4-Lite bus.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_POSITION = 8'h04;
	localparam logic [7:0] OFS_SCALE = 8'h08;
	localparam logic [7:0] OFS_LATCH = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_STATUS_CLR = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] OFS_GLOBAL = 8'h1C;

	// Bit positions in encoder_mode_config.
	localparam int MODE_POL_A = 0;
	localparam int MODE_POL_B = 1;
	localparam int MODE_N_POL = 2;
	localparam int MODE_CLR_CONT = 4;
	localparam int MODE_CLR_ONCE = 5;
	localparam int MODE_CLR_ENC = 6;
	localparam int MODE_DECIMAL = 10;
	// Bits of encoder_mode_config that hold storage.
	localparam logic [31:0] MODE_MASK = 32'h00000477;
	localparam logic [31:0] MODE_RESET = 32'h00000004;

	// Bit positions in global_config.
	localparam int GLOB_N_USED = 0;
	localparam logic [31:0] GLOB_RESET = 32'h00000001;

	// Reset value of the scale constant: a factor of 1.0.
	localparam logic [31:0] SCALE_RESET = 32'h00010000;

	// Status and interrupt bit positions.
	localparam int ST_N_CLEAR = 0;
	localparam int ST_N_LATCH = 1;
	localparam int ST_W = 2;

	// Decimal mode fraction wraps at this value.
	localparam logic [16:0] DEC_WRAP = 17'h02710;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : abn_encoder_pkg

// ==== rtl/abn_input_filter.sv ====
// Synchroniser and three-cycle spike filter for one encoder input.
`timescale 1ns/10ps
module abn_input_filter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pinIn,
	output logic filtered
);

	// Three-stage synchroniser; only stage two and three are compared.
	logic sync1;
	logic sync2;
	logic sync3;
	// Counts cycles for which the synchronised level differs from the output.
	logic [abn_encoder_pkg::FILTER_CNT_W-1:0] stableCnt;

	// Synchroniser chain; the first stage feeds nothing but the second.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end
		else
		begin
			sync1 <= pinIn;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// The output follows only a level that stood for the whole filter time.
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			stableCnt <= '0;
			filtered <= 1'b0;
		end
		else if ((sync2 == sync3) && (sync3 != filtered))
		begin
			// A new level is seen; accept it once it has lasted long enough.
			if (stableCnt == abn_encoder_pkg::FILTER_CNT_W'(abn_encoder_pkg::FILTER_CYCLES - 1))
			begin
				filtered <= sync3;
				stableCnt <= '0;
			end
			else
			begin
				stableCnt <= stableCnt + 1'b1;
			end
		end
		else
		begin
			// A short pulse restarts the count and is rejected.
			stableCnt <= '0;
		end
	end

endmodule : abn_input_filter

// ==== verif/abn_quadrature_encoder_counter_chk.sv ====
// Bus handshake and interrupt checker for the encoder counter.
`timescale 1ns/10ps
module abn_quadrature_encoder_counter_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	// All checks run on the core clock and rest during reset.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Both halves of a write taken at one edge.
	sequence wTake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// A read address taken.
	sequence rTake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (wTake |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (rTake |=> s_axi_rvalid)
		else $error("read data missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	resp_code_a: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_bresp[0] && !s_axi_rresp[0])
		else $error("illegal response code");
	irq_drop_a: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("interrupt fell without a write");
endmodule : abn_quadrature_encoder_counter_chk

bind abn_quadrature_encoder_counter abn_quadrature_encoder_counter_chk chk_u (.core_clk, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .irq);

// ==== verif/abn_encoder_model.sv ====
// Behavioural incremental quadrature encoder with a null channel.
`timescale 1ns/10ps
module abn_encoder_model #(
	parameter int HOLD = 10
) (
	input wire logic core_clk,
	output logic encA,
	output logic encB,
	output logic encN
);
	// Quadrature phase, 0 to 3 for A,B of 00, 10, 11, 01.
	logic [1:0] phase;

	// The encoder rests with all lines low.
	initial
	begin
		phase = 2'h0;
		encA = 1'b0;
		encB = 1'b0;
		encN = 1'b0;
	end

	// Holds the lines well above the minimum high and low time.
	task automatic idle();
		repeat (HOLD) @(posedge core_clk);
	endtask : idle

	// Moves the phase by d; a d of two changes both lines, which is corrupt.
	task automatic move(input logic [1:0] d);
		@(posedge core_clk);
		phase = phase + d;
		encA <= phase[0] ^ phase[1];
		encB <= phase[1];
		idle();
	endtask : move

	// One step forward or back, so only one line changes.
	task automatic step(input logic up);
		move(up ? 2'h1 : 2'h3);
	endtask : step

	// A one-cycle spike on A, shorter than the filter accepts.
	task automatic glitch();
		@(posedge core_clk);
		encA <= ~encA;
		@(posedge core_clk);
		encA <= ~encA;
		idle();
	endtask : glitch

	// One null pulse at the active high level.
	task automatic pulse();
		@(posedge core_clk);
		encN <= 1'b1;
		idle();
		encN <= 1'b0;
		idle();
	endtask : pulse
endmodule : abn_encoder_model

// ==== verif/abn_quadrature_encoder_counter_tb.sv ====
// Self-checking bench for the quadrature encoder counter.
`timescale 1ns/10ps
module abn_quadrature_encoder_counter_tb;
	// Clock, reset and encoder lines.
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic encA, encB, encN;
	// Bus master outputs.
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	// Slave answers and interrupt.
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	// Counters and random state.
	int n_fail = 0, n_compared = 0, n;
	logic [31:0] seed = 32'h6230FADD, sc;
	logic up;

	// The 100 MHz clock.
	always #5 core_clk = ~core_clk;

	abn_quadrature_encoder_counter dut_u (.core_clk, .rst, .encA, .encB, .encN, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	abn_encoder_model enc_u (.core_clk, .encA, .encB, .encN);

	// Next random word.
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// Integer position after n binary 16.16 steps.
	function automatic logic [31:0] binExp(input logic [31:0] s, input int k);
		return 32'((longint'(signed'(s)) * k) >>> 16);
	endfunction : binExp

	// Integer position after n decimal steps, rounded toward minus infinity.
	function automatic logic [31:0] decExp(input logic [31:0] s, input int k);
		longint t;
		t = (longint'(signed'(s[31:16])) * 10000 + int'(s[15:0])) * k;
		return 32'(t < 0 ? (t - 9999) / 10000 : t / 10000);
	endfunction : decExp

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// Compares one value and reports a difference.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// A handshake that never came ends the run.
	task automatic hang();
		n_fail++;
		$display("ERROR handshake expected 1 seen 0");
		stop_test();
	endtask : hang

	// One write; the response is accepted late so the slave must hold it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
		input logic [3:0] st = 4'hF);
		int i;
		i = 0;
		@(posedge core_clk);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			i++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (i >= 3 && !s_axi_bready) s_axi_bready <= s_axi_bvalid;
		end
		while (!(s_axi_bvalid && s_axi_bready) && i < 40);
		s_axi_bready <= 1'b0;
		if (!(s_axi_bvalid && s_axi_bready)) hang();
		check($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr

	// One read, checked against the expected word and response.
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
		int i;
		i = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			i++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (i >= 2 && !s_axi_rready) s_axi_rready <= s_axi_rvalid;
		end
		while (!(s_axi_rvalid && s_axi_rready) && i < 40);
		s_axi_rready <= 1'b0;
		if (!(s_axi_rvalid && s_axi_rready)) hang();
		check($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
		if (er == 2'h0) check($sformatf("rdata %h", a), s_axi_rdata, exp);
	endtask : rdc

	// Main sequence.
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rdc(abn_encoder_pkg::OFS_MODE, abn_encoder_pkg::MODE_RESET);
		rdc(abn_encoder_pkg::OFS_SCALE, abn_encoder_pkg::SCALE_RESET);
		rdc(abn_encoder_pkg::OFS_GLOBAL, abn_encoder_pkg::GLOB_RESET);
		for (int r = 4; r <= 24; r += 4)
			rdc(8'(r), (r == 8) ? abn_encoder_pkg::SCALE_RESET : 32'h0);
		rdc(8'h20, 32'h0, abn_encoder_pkg::RESP_SLVERR);
		rdc(32'h00000104, 32'h0, abn_encoder_pkg::RESP_SLVERR);
		// Only bytes 0 and 2 of the scale are replaced.
		wr(abn_encoder_pkg::OFS_SCALE, 32'hAABBCCDD, abn_encoder_pkg::RESP_OKAY, 4'h5);
		rdc(abn_encoder_pkg::OFS_SCALE, 32'h00BB00DD);
		wr(abn_encoder_pkg::OFS_LATCH, 32'h1, abn_encoder_pkg::RESP_SLVERR);
		wr(8'h02, 32'h1, abn_encoder_pkg::RESP_SLVERR);
		$display("done registers");
		// Random scales and step runs; the first scale is minus one.
		for (int k = 0; k < 5; k++)
		begin
			seed = lfsr(seed);
			sc = (k == 0) ? 32'hFFFF0000 : {{14{seed[20]}}, seed[17:0]};
			n = int'(seed[24:22]) + 1;
			up = seed[25];
			wr(abn_encoder_pkg::OFS_SCALE, sc);
			wr(abn_encoder_pkg::OFS_POSITION, 32'h0);
			repeat (n) enc_u.step(up);
			rdc(abn_encoder_pkg::OFS_POSITION, binExp(sc, up ? n : -n));
		end
		// Spikes and double changes do not count.
		wr(abn_encoder_pkg::OFS_POSITION, 32'h0);
		enc_u.glitch();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h0);
		enc_u.move(2'h2);
		enc_u.move(2'h2);
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h0);
		$display("done counting");
		// Decimal scales of plus and minus 25.6 across the fraction wrap.
		wr(abn_encoder_pkg::OFS_MODE, 32'h00000404);
		// Both signs, counted up for carries and down for borrows.
		for (int j = 0; j < 4; j++)
		begin
			sc = j[0] ? 32'hFFE60FA0 : 32'h00191770;
			wr(abn_encoder_pkg::OFS_SCALE, sc);
			wr(abn_encoder_pkg::OFS_POSITION, 32'h0);
			repeat (4) enc_u.step(j < 2);
			rdc(abn_encoder_pkg::OFS_POSITION, decExp(sc, (j < 2) ? 4 : -4));
		end
		wr(abn_encoder_pkg::OFS_MODE, abn_encoder_pkg::MODE_RESET);
		wr(abn_encoder_pkg::OFS_SCALE, abn_encoder_pkg::SCALE_RESET);
		$display("done decimal");
		// Continuous clear with A and B both required high.
		while (enc_u.phase != 2'h2) enc_u.step(1'b1);
		wr(abn_encoder_pkg::OFS_IRQ_EN, 32'h3);
		wr(abn_encoder_pkg::OFS_MODE, 32'h57);
		wr(abn_encoder_pkg::OFS_POSITION, 32'h5);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h0);
		rdc(abn_encoder_pkg::OFS_LATCH, 32'h5);
		rdc(abn_encoder_pkg::OFS_STATUS, 32'h3);
		check("irq", {31'h0, irq}, 32'h1);
		wr(abn_encoder_pkg::OFS_STATUS_CLR, 32'h3);
		rdc(abn_encoder_pkg::OFS_STATUS, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		enc_u.step(1'b1);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h1);
		repeat (3) enc_u.step(1'b1);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h0);
		// Single shot acts once and disarms itself.
		wr(abn_encoder_pkg::OFS_MODE, 32'h67);
		wr(abn_encoder_pkg::OFS_POSITION, 32'h7);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h0);
		rdc(abn_encoder_pkg::OFS_MODE, 32'h47);
		wr(abn_encoder_pkg::OFS_POSITION, 32'h7);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h7);
		// Latch without clear, then the null input switched off.
		wr(abn_encoder_pkg::OFS_MODE, 32'h17);
		wr(abn_encoder_pkg::OFS_POSITION, 32'h9);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h9);
		rdc(abn_encoder_pkg::OFS_LATCH, 32'h9);
		wr(abn_encoder_pkg::OFS_GLOBAL, 32'h0);
		wr(abn_encoder_pkg::OFS_MODE, 32'h57);
		wr(abn_encoder_pkg::OFS_POSITION, 32'h4);
		enc_u.pulse();
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h4);
		repeat (4) enc_u.step(1'b1);
		rdc(abn_encoder_pkg::OFS_POSITION, 32'h8);
		$display("done null channel");
		stop_test();
	end
endmodule : abn_quadrature_encoder_counter_tb
